//--- core/sr_pkg.sv
// constants and types for the serial configuration rom controller
package sr_pkg;
  // timing
  localparam int CLK_KHZ       = 50000;
  localparam int SK_KHZ        = 1000;
  localparam int SK_HALF       = CLK_KHZ / (2 * SK_KHZ);
  localparam int WRITE_TIME_US = 10000;
  localparam int WRITE_WAIT_CYC = WRITE_TIME_US * (CLK_KHZ / 1000);
  localparam logic [1:0] STRAP_DLY = 2'h3;
  localparam logic [4:0] SIZE_EDGE = 5'hA;
  localparam logic [4:0] HDR_BITS6 = 5'h9;
  localparam logic [4:0] HDR_BITS8 = 5'hB;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [4:0] RX_SPAN   = 5'h11;
  // register indices, byte address is four times the index
  localparam logic [9:0] CMD_IDX  = 10'h040;
  localparam logic [9:0] DATA_IDX = 10'h042;
  localparam logic [9:0] STAT_IDX = 10'h016;
  localparam logic [1:0] CFG_WIN  = 2'h2;
  localparam int CFG_WORDS = 256;
  // field positions
  localparam int INIT_DONE_BIT = 7;
  localparam int BUSY_BIT  = 8;
  localparam int VALID_BIT = 10;
  localparam int SEL_BIT   = 10;
  // opcodes and extended sub-codes
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WR  = 2'h1;
  localparam logic [1:0] OP_RD  = 2'h2;
  localparam logic [1:0] OP_ER  = 2'h3;
  localparam logic [1:0] EXT_WRAL = 2'h1;
  localparam logic [1:0] EXT_ERAL = 2'h2;
  localparam logic [15:0] NO_DATA = 16'hFFFF;
  localparam logic [7:0]  BOOT_ADDR = 8'h00;

  typedef enum logic [2:0] {S_STRAP, S_FRAME, S_GAP, S_WAIT, S_READY} st_t;
  typedef enum logic [2:0] {LD_HOST, LD_BHDR, LD_GHDR, LD_DATA, LD_CSUM} ld_t;
endpackage

//--- core/serial_rom_ctrl.sv
// serial configuration rom loader with apb command access
`timescale 1ns/1ns
module serial_rom_ctrl #(
  parameter int WRITE_WAIT = sr_pkg::WRITE_WAIT_CYC
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // serial rom link
  input  wire logic        rom_serial_in,
  output logic             rom_serial_out,
  output logic             rom_serial_clock,
  output logic             rom_select,
  output logic             ext_logic_select,
  // status
  output logic             init_done,
  output logic             serial_if_busy,
  output logic             rom_load_valid
);

  typedef struct packed {
    sr_pkg::st_t st;
    sr_pkg::ld_t ld;
    logic        di1;
    logic        di2;
    logic [1:0]  dly;
    logic [4:0]  ph;
    logic        sk;
    logic        csr;
    logic        cse;
    logic        dout;
    logic        boot;
    logic        aw8;
    logic        rxen;
    logic        post;
    logic        busy;
    logic [4:0]  edg;
    logic [4:0]  txl;
    logic [26:0] sh;
    logic [15:0] rx;
    logic [15:0] cmd;
    logic [15:0] data;
    logic [7:0]  waddr;
    logic [7:0]  dst;
    logic [7:0]  remain;
    logic [7:0]  sum;
    logic [3:0]  cnt;
    logic        valid;
    logic        done;
    logic [19:0] tmr;
    logic [31:0] rdata;
    logic        err;
    logic [sr_pkg::CFG_WORDS-1:0][15:0] mem;
  } state_t;

  state_t s_q;
  state_t s_d;

  // loads the shift register with start bit, opcode, address and data
  function automatic state_t launch(state_t s, logic [1:0] op, logic [7:0] a,
                                    logic [15:0] d, logic dat);
    s.sh   = s.aw8 ? {1'b1, op, a, d} : {1'b1, op, a[5:0], d, 2'b00};
    s.txl  = (s.aw8 ? sr_pkg::HDR_BITS8 : sr_pkg::HDR_BITS6) + (dat ? sr_pkg::DATA_BITS : 5'h00);
    s.dout = 1'b1;
    s.edg  = '0;
    s.ph   = '0;
    s.sk   = 1'b0;
    s.st   = sr_pkg::S_FRAME;
    return s;
  endfunction

  logic [4:0]  e_nxt;
  logic [4:0]  total;
  logic [15:0] w;
  logic [1:0]  op;
  logic [1:0]  top;
  logic        fail;
  logic        fin;
  logic [31:0] stat;

  always_comb begin
    s_d   = s_q;
    w     = s_q.rx;
    fail  = 1'b0;
    fin   = 1'b0;
    op    = s_q.cmd[9:8];
    top   = s_q.aw8 ? s_q.cmd[7:6] : s_q.cmd[5:4];
    e_nxt = s_q.edg + 5'h01;
    total = s_q.rxen ? s_q.txl + sr_pkg::RX_SPAN : s_q.txl;
    stat  = '0;
    stat[sr_pkg::INIT_DONE_BIT] = s_q.done;
    stat[sr_pkg::BUSY_BIT]  = s_q.busy;
    stat[sr_pkg::VALID_BIT] = s_q.valid;
    s_d.di1 = rom_serial_in;
    s_d.di2 = s_q.di1;

    // apb: read data and error latched in the setup cycle
    if (psel && !penable) begin
      s_d.err   = 1'b0;
      s_d.rdata = '0;
      if (paddr[11:2] == sr_pkg::CMD_IDX) begin
        s_d.rdata = {16'h0000, s_q.cmd};
      end else if (paddr[11:2] == sr_pkg::DATA_IDX) begin
        s_d.rdata = {16'h0000, s_q.data};
      end else if (paddr[11:2] == sr_pkg::STAT_IDX) begin
        s_d.rdata = stat;
      end else if (paddr[11:10] == sr_pkg::CFG_WIN) begin
        s_d.rdata = {16'h0000, s_q.mem[paddr[9:2]]};
      end else begin
        s_d.err = 1'b1;
      end
    end

    case (s_q.st)
      sr_pkg::S_STRAP: begin
        if (s_q.dly == sr_pkg::STRAP_DLY) begin
          if (s_q.di2) begin
            s_d.aw8  = 1'b1;
            s_d      = launch(s_d, sr_pkg::OP_RD, sr_pkg::BOOT_ADDR, 16'h0000, 1'b0);
            s_d.csr  = 1'b1;
            s_d.boot = 1'b1;
            s_d.rxen = 1'b1;
            s_d.post = 1'b0;
            s_d.ld   = sr_pkg::LD_BHDR;
            s_d.waddr = sr_pkg::BOOT_ADDR;
          end else begin
            s_d.st   = sr_pkg::S_READY;
            s_d.done = 1'b1;
          end
        end else begin
          s_d.dly = s_q.dly + 2'h1;
        end
      end
      sr_pkg::S_FRAME: begin
        if (s_q.ph == 5'(sr_pkg::SK_HALF - 1)) begin
          s_d.ph = '0;
          if (!s_q.sk) begin
            s_d.sk  = 1'b1;
            s_d.edg = e_nxt;
            if (s_q.boot && e_nxt == sr_pkg::SIZE_EDGE) begin
              s_d.aw8 = s_q.di2;
              if (!s_q.di2) begin
                s_d.txl = sr_pkg::HDR_BITS6;
              end
            end
            if (s_q.rxen && e_nxt >= s_q.txl + 5'h02) begin
              s_d.rx = {s_q.rx[14:0], s_q.di2};
            end
          end else begin
            s_d.sk = 1'b0;
            if (s_q.edg == total) begin
              s_d.csr  = 1'b0;
              s_d.cse  = 1'b0;
              s_d.dout = 1'b0;
              s_d.st   = s_q.post ? sr_pkg::S_WAIT : sr_pkg::S_GAP;
              if (s_q.ld == sr_pkg::LD_HOST && s_q.rxen) begin
                s_d.data = s_q.rx;
              end
            end else begin
              s_d.sh   = {s_q.sh[25:0], 1'b0};
              s_d.dout = s_q.sh[25];
            end
          end
        end else begin
          s_d.ph = s_q.ph + 5'h01;
        end
      end
      sr_pkg::S_WAIT: begin
        if (s_q.tmr == 20'(WRITE_WAIT - 1)) begin
          s_d.tmr = '0;
          s_d.st  = sr_pkg::S_READY;
        end else begin
          s_d.tmr = s_q.tmr + 20'h00001;
        end
      end
      sr_pkg::S_GAP: begin
        if (s_q.ph == 5'(sr_pkg::SK_HALF - 1)) begin
          s_d.ph = '0;
          case (s_q.ld)
            sr_pkg::LD_HOST: begin
              s_d.st = sr_pkg::S_READY;
            end
            sr_pkg::LD_BHDR: begin
              s_d.boot = 1'b0;
              if (w == sr_pkg::NO_DATA) begin
                fin = 1'b1;
              end else begin
                s_d.remain = w[7:0];
                s_d.sum    = w[15:8] + w[7:0];
                // link byte covers the checksum word too
                s_d.ld     = (w[7:0] <= 8'h02) ? sr_pkg::LD_CSUM : sr_pkg::LD_GHDR;
              end
            end
            sr_pkg::LD_GHDR: begin
              if (w == sr_pkg::NO_DATA) begin
                fail = 1'b1;
              end else begin
                s_d.cnt    = w[15:12];
                s_d.dst    = w[8:1];
                s_d.sum    = s_q.sum + w[15:8] + w[7:0];
                s_d.remain = s_q.remain - 8'h02;
                s_d.ld     = (s_q.remain <= 8'h04) ? sr_pkg::LD_CSUM : sr_pkg::LD_DATA;
              end
            end
            sr_pkg::LD_DATA: begin
              if (w == sr_pkg::NO_DATA) begin
                fail = 1'b1;
              end else begin
                s_d.mem[s_q.dst] = w;
                s_d.dst    = s_q.dst + 8'h01;
                s_d.cnt    = s_q.cnt - 4'h1;
                s_d.sum    = s_q.sum + w[15:8] + w[7:0];
                s_d.remain = s_q.remain - 8'h02;
                if (s_q.remain <= 8'h04) begin
                  s_d.ld = sr_pkg::LD_CSUM;
                end else if (s_q.cnt == 4'h0) begin
                  s_d.ld = sr_pkg::LD_GHDR;
                end
              end
            end
            default: begin
              if (8'(s_q.sum + w[15:8]) == 8'h00) begin
                fin       = 1'b1;
                s_d.valid = 1'b1;
              end else begin
                fail = 1'b1;
              end
            end
          endcase
          if (fail) begin
            s_d.mem   = '0;
            s_d.valid = 1'b0;
            fin       = 1'b1;
          end
          if (fin) begin
            s_d.ld   = sr_pkg::LD_HOST;
            s_d.st   = sr_pkg::S_READY;
            s_d.done = 1'b1;
          end else if (s_q.ld != sr_pkg::LD_HOST) begin
            s_d.waddr = s_q.waddr + 8'h01;
            s_d = launch(s_d, sr_pkg::OP_RD, s_d.waddr, 16'h0000, 1'b0);
            s_d.csr = 1'b1;
          end
        end else begin
          s_d.ph = s_q.ph + 5'h01;
        end
      end
      default: begin
      end
    endcase

    // apb writes take effect in the access cycle, only while in S_READY
    if (psel && penable && pwrite && s_q.st == sr_pkg::S_READY) begin
      if (paddr[11:2] == sr_pkg::DATA_IDX) begin
        s_d.data = pwdata[15:0];
      end else if (paddr[11:2] == sr_pkg::CMD_IDX) begin
        s_d.cmd = pwdata[15:0];
        op  = pwdata[9:8];
        top = s_q.aw8 ? pwdata[7:6] : pwdata[5:4];
        s_d.rxen = (op == sr_pkg::OP_RD);
        s_d.post = op == sr_pkg::OP_WR || op == sr_pkg::OP_ER ||
                   (op == sr_pkg::OP_EXT && (top == sr_pkg::EXT_WRAL || top == sr_pkg::EXT_ERAL));
        s_d = launch(s_d, op, pwdata[7:0], s_q.data,
                     op == sr_pkg::OP_WR || (op == sr_pkg::OP_EXT && top == sr_pkg::EXT_WRAL));
        s_d.csr = !pwdata[sr_pkg::SEL_BIT];
        s_d.cse = pwdata[sr_pkg::SEL_BIT];
      end
    end
    s_d.busy = (s_d.st != sr_pkg::S_READY);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready           = 1'b1;
  assign prdata           = s_q.rdata;
  assign pslverr          = s_q.err;
  assign rom_serial_out   = s_q.dout;
  assign rom_serial_clock = s_q.sk;
  assign rom_select       = s_q.csr;
  assign ext_logic_select = s_q.cse;
  assign init_done        = s_q.done;
  assign serial_if_busy   = s_q.busy;
  assign rom_load_valid   = s_q.valid;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_clk_idle_low: assert property (!(rom_select || ext_logic_select) |-> !rom_serial_clock)
    else $error("serial clock active with no select");
  a_clk_half_period: assert property ($rose(rom_serial_clock) |-> ##25 $fell(rom_serial_clock))
    else $error("serial clock high phase not 25 cycles");
  a_strap_high_sel: assert property (s_q.st == sr_pkg::S_STRAP && s_q.dly == sr_pkg::STRAP_DLY && s_q.di2
    |=> rom_select && rom_serial_out)
    else $error("boot read not started");
  a_strap_low_skip: assert property (s_q.st == sr_pkg::S_STRAP && s_q.dly == sr_pkg::STRAP_DLY && !s_q.di2
    |=> init_done && !rom_select && !rom_load_valid)
    else $error("read-out not skipped");
  a_size_sample: assert property (s_q.boot && $rose(rom_serial_clock) && s_q.edg == sr_pkg::SIZE_EDGE
    |-> s_q.aw8 == $past(s_q.di2))
    else $error("address width not taken at tenth edge");
  a_valid_init: assert property ($rose(rom_load_valid) |-> init_done && !serial_if_busy)
    else $error("valid without init done");
  a_select_busy: assert property ((rom_select || ext_logic_select) |-> serial_if_busy)
    else $error("select active while not busy");
  a_select_one: assert property (!(rom_select && ext_logic_select))
    else $error("both select pins active");
  a_cmd_start: assert property (psel && penable && pwrite && paddr[11:2] == sr_pkg::CMD_IDX &&
    s_q.st == sr_pkg::S_READY |=> serial_if_busy && (rom_select != ext_logic_select))
    else $error("command not started");

  c_boot_valid: cover property ($rose(rom_load_valid));
  c_no_config: cover property ($rose(init_done) && !rom_load_valid && $past(s_q.ld) == sr_pkg::LD_BHDR);
  c_host_read: cover property ($fell(serial_if_busy) && s_q.rxen && s_q.ld == sr_pkg::LD_HOST);
  c_wide_rom: cover property (s_q.aw8 && !s_q.boot && init_done);

endmodule

//--- tb/rom_model.sv
// behavioural three-wire serial rom with write protection
`timescale 1ns/1ns
module rom_model #(
  parameter int ABITS = 6
) (
  // link
  input  wire logic sk,
  input  wire logic cs,
  input  wire logic di,
  output logic      dout
);
  localparam int HB = 3 + ABITS;
  logic [15:0] mem [256];
  logic [31:0] sh;
  logic [1:0]  op;
  logic [7:0]  a;
  logic        wen;
  int          n;
  int          k;
  initial begin
    wen  = 1'b0;
    dout = 1'b1;
    n    = 0;
  end
  // bits taken on rising clock, read data changes after it
  always @(posedge sk) begin
    if (cs) begin
      sh = {sh[30:0], di};
      n  = n + 1;
      if (n == HB) begin
        op = sh[ABITS+1 -: 2];
        a  = 8'(sh[ABITS-1:0]);
      end
      if (n == HB && op == sr_pkg::OP_RD) begin
        dout = 1'b0;
      end else if (n > HB && op == sr_pkg::OP_RD) begin
        k    = n - HB - 1;
        dout = mem[(a + k / 16) % (1 << ABITS)][15 - k % 16];
      end
    end
  end
  // commit on deselect; pull-up level when released
  always @(negedge cs) begin
    if (n >= HB && wen) begin
      if (op == sr_pkg::OP_ER) begin
        mem[a] = 16'hFFFF;
      end
      if (op == sr_pkg::OP_WR && n >= HB + 16) begin
        mem[a] = sh[15:0];
      end
      if (op == sr_pkg::OP_EXT && a[ABITS-1 -: 2] == sr_pkg::EXT_ERAL) begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
      end
      if (op == sr_pkg::OP_EXT && a[ABITS-1 -: 2] == sr_pkg::EXT_WRAL && n >= HB + 16) begin
        for (int i = 0; i < 256; i++) mem[i] = sh[15:0];
      end
    end
    if (n >= HB && op == sr_pkg::OP_EXT && a[ABITS-1 -: 2] == 2'h3) wen = 1'b1;
    if (n >= HB && op == sr_pkg::OP_EXT && a[ABITS-1 -: 2] == 2'h0) wen = 1'b0;
    n    = 0;
    dout = 1'b1;
  end
endmodule

//--- tb/tb_serial_rom_ctrl.sv
// bench for the serial rom loader: boot cases and host commands
`timescale 1ns/1ns
module tb_serial_rom_ctrl;
  localparam logic [11:0] CMD  = {sr_pkg::CMD_IDX, 2'h0};
  localparam logic [11:0] DAT  = {sr_pkg::DATA_IDX, 2'h0};
  localparam logic [11:0] STAT = {sr_pkg::STAT_IDX, 2'h0};
  localparam logic [11:0] CFG  = 12'h840;
  logic        clk_sys;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        rom_in;
  logic        rom_dout;
  logic        rom_wide_dout;
  logic        wide;
  logic        rom_serial_out;
  logic        rom_serial_clock;
  logic        rom_select;
  logic        ext_logic_select;
  logic        init_done;
  logic        serial_if_busy;
  logic        rom_load_valid;
  logic        strap_low;
  logic [31:0] r;
  logic        e;
  int          n_errors;
  int          check_count;
  int          sel_n;
  int          ext_n;
  int          per;
  int          k;
  time         t_rise;
  assign rom_in = strap_low ? 1'b0 : (wide ? rom_wide_dout : rom_dout);
  serial_rom_ctrl #(.WRITE_WAIT(200)) serial_rom_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rom_serial_in(rom_in), .rom_serial_out(rom_serial_out),
    .rom_serial_clock(rom_serial_clock), .rom_select(rom_select), .ext_logic_select(ext_logic_select),
    .init_done(init_done), .serial_if_busy(serial_if_busy), .rom_load_valid(rom_load_valid));
  rom_model #(.ABITS(6)) rom_model_i (.sk(rom_serial_clock), .cs(rom_select && !wide), .di(rom_serial_out),
    .dout(rom_dout));
  rom_model #(.ABITS(8)) rom_wide_i (.sk(rom_serial_clock), .cs(rom_select && wide), .di(rom_serial_out),
    .dout(rom_wide_dout));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge rom_select) sel_n++;
  always @(posedge ext_logic_select) ext_n++;
  always @(posedge rom_serial_clock) begin
    per    = int'($time - t_rise);
    t_rise = $time;
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int t;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t == 50) begin
      chk(32'h0, 32'h1);
      stop_test();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 16'h0000);
    chk(r, x);
  endtask
  task automatic idle;
    int t;
    t = 0;
    while ((serial_if_busy !== 1'b0 || init_done !== 1'b1) && t < 20000) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    if (t == 20000) begin
      chk(32'h0, 32'h1);
      stop_test();
    end
  endtask
  task automatic cmd(input logic [15:0] c);
    apb(1'b1, CMD, c);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, serial_if_busy}, 32'h1);
    idle();
    chk({29'h0, rom_select, rom_serial_clock, ext_logic_select}, 32'h0);
  endtask
  task automatic boot(input logic s);
    strap_low <= s;
    sys_rst   <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst   <= 1'b0;
    repeat (8) @(posedge clk_sys);
    strap_low <= 1'b0;
    idle();
  endtask
  task automatic img(input logic [15:0] w0, input logic [15:0] cs);
    for (int i = 0; i < 256; i++) rom_model_i.mem[i] = 16'hFFFF;
    rom_model_i.mem[0] = w0;
    rom_model_i.mem[1] = 16'h0020;
    rom_model_i.mem[2] = 16'h1234;
    rom_model_i.mem[3] = cs;
  endtask
  initial begin
    n_errors = 0;
    check_count = 0;
    sel_n = 0;
    ext_n = 0;
    per = 0;
    t_rise = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap_low = 1'b0;
    wide = 1'b0;
    img(16'hA106, 16'hF300);
    boot(1'b0);
    rd(STAT, 32'h0000_0480);
    chk({31'h0, rom_load_valid}, 32'h1);
    rd(CFG, 32'h0000_1234);
    rd(CFG + 12'h004, 32'h0);
    img(16'hA106, 16'hF400);
    boot(1'b0);
    rd(STAT, 32'h0000_0080);
    rd(CFG, 32'h0);
    chk({31'h0, rom_load_valid}, 32'h0);
    img(16'hFFFF, 16'hF300);
    boot(1'b0);
    rd(STAT, 32'h0000_0080);
    k = sel_n;
    boot(1'b1);
    chk(sel_n, k);
    rd(STAT, 32'h0000_0080);
    cmd(16'h0030);
    apb(1'b1, DAT, 16'hBEEF);
    cmd(16'h0105);
    cmd(16'h0000);
    chk({16'h0, rom_model_i.mem[5]}, 32'h0000_BEEF);
    apb(1'b1, DAT, 16'h0000);
    cmd(16'h0205);
    rd(DAT, 32'h0000_BEEF);
    chk(per, 1000);
    apb(1'b1, CMD, 16'h0030);
    rd(STAT, 32'h0000_0180);
    apb(1'b1, DAT, 16'h1111);
    apb(1'b1, CMD, 16'h0305);
    idle();
    rd(DAT, 32'h0000_BEEF);
    rd(CMD, 32'h0000_0030);
    cmd(16'h0030);
    cmd(16'h0305);
    chk({16'h0, rom_model_i.mem[5]}, 32'h0000_FFFF);
    apb(1'b1, DAT, 16'h5A5A);
    cmd(16'h0010);
    chk({16'h0, rom_model_i.mem[9]}, 32'h0000_5A5A);
    cmd(16'h0020);
    chk({16'h0, rom_model_i.mem[9]}, 32'h0000_FFFF);
    cmd(16'h0000);
    k = sel_n;
    cmd(16'h0605);
    chk(sel_n, k);
    chk(ext_n, 1);
    // wide rom: width sensed high at the tenth edge, eight address bits after
    wide <= 1'b1;
    img(16'hA106, 16'hF300);
    for (int i = 0; i < 256; i++) rom_wide_i.mem[i] = rom_model_i.mem[i];
    rom_wide_i.mem[9] = 16'hC3A5;
    boot(1'b0);
    rd(STAT, 32'h0000_0480);
    rd(CFG, 32'h0000_1234);
    cmd(16'h0209);
    rd(DAT, 32'h0000_C3A5);
    cmd(16'h00C0);
    apb(1'b1, DAT, 16'h7E81);
    cmd(16'h0109);
    cmd(16'h0000);
    chk({16'h0, rom_wide_i.mem[9]}, 32'h0000_7E81);
    apb(1'b0, 12'hFFC, 16'h0000);
    chk({31'h0, e}, 32'h1);
    stop_test();
  end
endmodule
